// file: design/rvl_input_latch.sv
// Input latch and output selection for the RGB video converter
`timescale 1ns/10ps
module rvl_input_latch #(
    parameter int CODE_W = rvl_pkg::RVL_CODE_W
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [CODE_W-1:0] red_code_in,
    input wire logic [CODE_W-1:0] green_code_in,
    input wire logic [CODE_W-1:0] blue_code_in,
    input wire logic blank_n_in,
    input wire logic sync_n_in,
    output logic [CODE_W-1:0] red_current_out,
    output logic [CODE_W-1:0] green_current_out,
    output logic [CODE_W-1:0] blue_current_out,
    output logic green_sync_on_out,
    output logic blanked_out
);
    import rvl_pkg::*;

    // Channel order inside the arrays
    localparam int N_CH = 3;

    localparam int CH_RED = 0;

    localparam int CH_GREEN = 1;

    localparam int CH_BLUE = 2;

    // Blanking level at the channel width
    localparam logic [CODE_W-1:0] BLANK_CODE = CODE_W'(RVL_BLANK_CODE);

    // Reset value of every channel register
    localparam logic [CODE_W-1:0] CODE_RST = CODE_W'(RVL_CODE_RST);

    // Reset value of the blank flag, high while blanked
    localparam logic BLANKED_RST = ~RVL_BLANK_RST;

    // Reset value of the sync current enable
    localparam logic SYNC_ON_RST = RVL_SYNC_RST;

    // Chooses the pixel code or the blanking level
    function automatic logic [CODE_W-1:0] blank_select(
        input logic pass,
        input logic [CODE_W-1:0] code
    );
        logic [CODE_W-1:0] sel;
        sel = BLANK_CODE;
        if (pass) begin
            sel = code;
        end
        return sel;
    endfunction

    // Active-low blank means colour data passes while high
    function automatic logic data_passes(
        input logic blank_n
    );
        return blank_n;
    endfunction

    // Active-low sync means the sync current is on while high
    function automatic logic sync_current_on(
        input logic sync_n
    );
        return sync_n;
    endfunction

    // Colour inputs gathered by channel
    wire logic [CODE_W-1:0] code_in [N_CH];

    // Selected codes ahead of the register stage
    wire logic [CODE_W-1:0] code_next [N_CH];

    // Registered codes behind the register stage
    wire logic [CODE_W-1:0] code_q [N_CH];

    // Decoded controls
    wire logic pass_data;

    wire logic blanked_next;

    wire logic sync_on_next;

    // Registered controls
    logic blanked_reg;

    logic sync_on_reg;

    // Gather the three colour words
    assign code_in[CH_RED] = red_code_in;

    assign code_in[CH_GREEN] = green_code_in;

    assign code_in[CH_BLUE] = blue_code_in;

    // Blank low forces the blanking level and ignores pixel data
    assign pass_data = data_passes(blank_n_in);

    assign blanked_next = ~pass_data;

    // Sync acts on its own, whatever blank or data do
    assign sync_on_next = sync_current_on(sync_n_in);

    // One register per colour channel
    genvar ch;
    generate
        for (ch = 0; ch < N_CH; ch++) begin : g_chan
            logic [CODE_W-1:0] chan_reg;

            assign code_next[ch] = blank_select(pass_data, code_in[ch]);

            always_ff @(posedge clk_sys) begin
                if (sys_rst) begin
                    chan_reg <= CODE_RST;
                end else begin
                    chan_reg <= code_next[ch];
                end
            end

            assign code_q[ch] = chan_reg;
        end
    endgenerate

    // Blank flag, captured on the same edge as the data
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            blanked_reg <= BLANKED_RST;
        end else begin
            blanked_reg <= blanked_next;
        end
    end

    // Sync current enable, captured on the same edge as the data
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sync_on_reg <= SYNC_ON_RST;
        end else begin
            sync_on_reg <= sync_on_next;
        end
    end

    // Outputs come straight from the registers
    assign red_current_out = code_q[CH_RED];

    assign green_current_out = code_q[CH_GREEN];

    assign blue_current_out = code_q[CH_BLUE];

    assign blanked_out = blanked_reg;

    assign green_sync_on_out = sync_on_reg;

endmodule

// file: design/rvl_pkg.sv
// Constants for the RGB video converter input latch
package rvl_pkg;
    localparam int RVL_CODE_W = 8;
    localparam logic [7:0] RVL_BLANK_CODE = 8'h00;
    localparam logic [7:0] RVL_CODE_RST = 8'h00;
    localparam logic RVL_BLANK_RST = 1'b0;
    localparam logic RVL_SYNC_RST = 1'b0;
    localparam int RVL_SYNC_IRE = 40;
    localparam int RVL_PIPE_CYCLES = 1;
endpackage

// file: tb/rvl_ctl_model.sv
// Pixel controller model: one new pixel each clock, sync only inside blanking while sync_used is high, sync_n_in held low when it is low
`timescale 1ns/10ps
module rvl_ctl_model (
    input wire logic clk_sys,
    input wire logic sync_used,
    output logic [7:0] cnt,
    output logic blank_n_in,
    output logic sync_n_in
);
    initial cnt = 8'h00;
    always @(posedge clk_sys) cnt <= #1 cnt + 8'h01;
    assign blank_n_in = !cnt[3];
    assign sync_n_in = sync_used ? !(cnt[3] && cnt[2]) : 1'b0;
endmodule

// file: tb/rvl_input_latch_sva.sv
// Checker for the input latch outputs
`timescale 1ns/10ps
module rvl_input_latch_sva (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] red_code_in,
    input wire logic [7:0] green_code_in,
    input wire logic [7:0] blue_code_in,
    input wire logic [7:0] red_current_out,
    input wire logic [7:0] green_current_out,
    input wire logic [7:0] blue_current_out,
    input wire logic blank_n_in,
    input wire logic sync_n_in,
    input wire logic green_sync_on_out,
    input wire logic blanked_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    AST_PIX: assert property (!$past(sys_rst) |->
        {red_current_out, green_current_out, blue_current_out} == ($past(blank_n_in) ?
        $past({red_code_in, green_code_in, blue_code_in}) : 24'h000000)) else $error("bad pixel");
    AST_SYNC: assert property (!$past(sys_rst) |-> green_sync_on_out == $past(sync_n_in))
        else $error("bad sync");
    AST_BLANK: assert property (!$past(sys_rst) |-> blanked_out == !$past(blank_n_in))
        else $error("bad blank");
    AST_RST_STATE: assert property ($past(sys_rst) |-> blanked_out && !green_sync_on_out &&
        {red_current_out, green_current_out, blue_current_out} == 24'h000000)
        else $error("bad state after reset");
    AST_BLANK_ZERO: assert property (blanked_out |->
        {red_current_out, green_current_out, blue_current_out} == 24'h000000)
        else $error("codes not at blanking level");
    AST_GREEN_PASS: assert property (!$past(sys_rst) && !blanked_out |->
        green_current_out == $past(green_code_in))
        else $error("bad green code");
endmodule
bind rvl_input_latch rvl_input_latch_sva i_sva (.*);

// file: tb/tb.sv
// Self-checking bench for the input latch
`timescale 1ns/10ps
module tb;
    logic clk_sys = 1'b0, sys_rst = 1'b1, sync_used = 1'b1, b_n, s_n, so, bl;
    logic [7:0] cnt, ro, go, bo;
    logic [25:0] exp_v;
    int n_fail = 0, checks_done = 0;
    always #2.5 clk_sys = !clk_sys;
    rvl_ctl_model i_rvl_ctl_model (.clk_sys(clk_sys), .sync_used(sync_used), .cnt(cnt),
        .blank_n_in(b_n), .sync_n_in(s_n));
    rvl_input_latch i_rvl_input_latch (.clk_sys(clk_sys), .sys_rst(sys_rst), .red_code_in(cnt),
        .green_code_in(~cnt), .blue_code_in(cnt ^ 8'h5a), .blank_n_in(b_n), .sync_n_in(s_n),
        .red_current_out(ro), .green_current_out(go), .blue_current_out(bo),
        .green_sync_on_out(so), .blanked_out(bl));
    task automatic chk(input logic [25:0] seen, input logic [25:0] exp);
        checks_done++;
        n_fail += int'(seen !== exp);
        if (seen !== exp) $display("unexpected pixel exp %h seen %h", exp, seen);
    endtask
    task automatic stop_test;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic run_stream;
        repeat (40) begin
            exp_v = {b_n ? {cnt, ~cnt, cnt ^ 8'h5a} : 24'h000000, s_n, !b_n};
            @(posedge clk_sys) #2;
            chk({ro, go, bo, so, bl}, exp_v);
        end
    endtask
    task automatic run_reset;
        @(posedge clk_sys) #1 sys_rst = 1'b1;
        @(posedge clk_sys) #1 sys_rst = 1'b0;
        #1 chk({ro, go, bo, so, bl}, {24'h000000, 1'b0, 1'b1});
    endtask
    task automatic run_no_sync;
        @(posedge clk_sys) #1 sync_used = 1'b0;
        #1 run_stream();
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        #1 chk({ro, go, bo, so, bl}, {24'h000000, 1'b0, 1'b1});
        run_stream();
        run_reset();
        run_stream();
        run_no_sync();
        stop_test();
    end
endmodule
